// File: design/dgf_fifo_mem.v
// Shared data storage for the per-pin input FIFOs
`timescale 1ns/1ps
module dgf_fifo_mem #(
    parameter W = 14,
    parameter AW = 3
) (
    // Clock
    input wire i_clk,
    // Write port
    input wire i_we,
    input wire [AW-1:0] i_waddr,
    input wire [W-1:0] i_wdata,
    // Read port
    input wire i_re,
    input wire [AW-1:0] i_raddr,
    output reg [W-1:0] o_rdata
);

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [W-1:0] mem [0:(1<<AW)-1];

always @(posedge i_clk)
begin
    if (i_we)
    begin
        mem[i_waddr] <= i_wdata;
    end
    if (i_re)
    begin
        o_rdata <= mem[i_raddr];
    end
end

endmodule

// File: design/dgf_map.vh
// Constants of the strobe-group gearing FIFO
`ifndef DGF_MAP_VH
`define DGF_MAP_VH

// ----------------------------------------------------------------
// Group geometry
// ----------------------------------------------------------------
`define DGF_GROUP_PINS 16
`define DGF_STROBE_PINS 2
`define DGF_DATA_PINS 14
`define DGF_FIFO_AW 3

// ----------------------------------------------------------------
// Gearing modes and word widths
// ----------------------------------------------------------------
`define DGF_MODE_X1 2'h0
`define DGF_MODE_X2 2'h1
`define DGF_MODE_7TO1 2'h2
`define DGF_WORD_MAX 7
`define DGF_WIDTH_X1 3'h2
`define DGF_WIDTH_X2 3'h4
`define DGF_WIDTH_7TO1 3'h7

// ----------------------------------------------------------------
// Write clock phases, one i_clk cycle each, quarter periods of the write clock
// ----------------------------------------------------------------
`define DGF_PH_SHIFT 2'h2
`define DGF_PH_RESET 2'h0

`endif

// File: design/dgf_strobe_group.v
// One strobe group: input FIFOs, gearing, output and tristate paths
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "dgf_map.vh"
module dgf_strobe_group #(
    parameter NUM_DATA = `DGF_DATA_PINS,
    parameter AW = `DGF_FIFO_AW,
    parameter TOP_SIDE = 0
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Link clocks from pins
    input wire i_strobe_delayed,
    input wire i_edge_clock,
    input wire i_slow_clock,
    // Pad inputs
    input wire [NUM_DATA-1:0] i_dq_in,
    // Core side control
    input wire [1:0] i_gear_mode,
    input wire i_word_align_request,
    input wire i_tristate_two_to_one_gear,
    input wire [1:0] i_tristate_in,
    input wire [NUM_DATA*`DGF_WORD_MAX-1:0] i_tx_word,
    // Core side data
    output wire [NUM_DATA*`DGF_WORD_MAX-1:0] o_rx_word,
    output reg o_rx_word_valid,
    // Pad outputs
    output wire [NUM_DATA-1:0] o_dq_out,
    output reg o_tristate_out,
    output reg o_strobe_p,
    output reg o_strobe_n,
    // Write clocks and pointers
    output reg o_strobe_write_clock,
    output reg o_data_write_clock_270,
    output reg [AW:0] o_wr_ptr,
    output reg [AW:0] o_rd_ptr
);

// ----------------------------------------------------------------
// Gear width decode
// ----------------------------------------------------------------
function [2:0] gear_width;
    input [1:0] mode;
    begin
        case (mode)
            `DGF_MODE_X1: gear_width = `DGF_WIDTH_X1;
            `DGF_MODE_X2: gear_width = `DGF_WIDTH_X2;
            `DGF_MODE_7TO1: gear_width = `DGF_WIDTH_7TO1;
            default: gear_width = `DGF_WIDTH_X1;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// Pin synchronisers and edge finders
// ----------------------------------------------------------------
reg [2:0] stb_s_r;
reg [2:0] ecl_s_r;
reg [2:0] slw_s_r;
reg [NUM_DATA-1:0] dq_s1_r;
reg [NUM_DATA-1:0] dq_s2_r;

always @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        stb_s_r <= 3'h0;
        ecl_s_r <= 3'h0;
        slw_s_r <= 3'h0;
        dq_s1_r <= {NUM_DATA{1'b0}};
        dq_s2_r <= {NUM_DATA{1'b0}};
    end
    else
    begin
        stb_s_r <= {stb_s_r[1:0], i_strobe_delayed};
        ecl_s_r <= {ecl_s_r[1:0], i_edge_clock};
        slw_s_r <= {slw_s_r[1:0], i_slow_clock};
        dq_s1_r <= i_dq_in;
        dq_s2_r <= dq_s1_r;
    end
end

wire stb_edge = stb_s_r[2] ^ stb_s_r[1];
wire ecl_edge = ecl_s_r[2] ^ ecl_s_r[1];
wire slw_rise = slw_s_r[1] & ~slw_s_r[2];

// ----------------------------------------------------------------
// FIFO control unit
// ----------------------------------------------------------------
wire fifo_full = (o_wr_ptr[AW] != o_rd_ptr[AW]) &&
    (o_wr_ptr[AW-1:0] == o_rd_ptr[AW-1:0]);
wire fifo_empty = (o_wr_ptr == o_rd_ptr);
wire fifo_we = stb_edge & ~fifo_full;
wire fifo_re = ecl_edge & ~fifo_empty;
wire [NUM_DATA-1:0] fifo_rdata;
reg rd_vld_r;

always @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        o_wr_ptr <= {(AW+1){1'b0}};
        o_rd_ptr <= {(AW+1){1'b0}};
        rd_vld_r <= 1'b0;
    end
    else
    begin
        if (fifo_we)
            o_wr_ptr <= o_wr_ptr + 1'b1;
        if (fifo_re)
            o_rd_ptr <= o_rd_ptr + 1'b1;
        rd_vld_r <= fifo_re;
    end
end

// Column p of this memory is the FIFO of data pin p
dgf_fifo_mem #(
    .W(NUM_DATA),
    .AW(AW)
) u_mem (
    .i_clk(i_clk),
    .i_we(fifo_we),
    .i_waddr(o_wr_ptr[AW-1:0]),
    .i_wdata(dq_s2_r),
    .i_re(fifo_re),
    .i_raddr(o_rd_ptr[AW-1:0]),
    .o_rdata(fifo_rdata)
);

// ----------------------------------------------------------------
// Deserializer bit count and alignment
// ----------------------------------------------------------------
wire [1:0] out_mode = (TOP_SIDE != 0) ? `DGF_MODE_X1 : i_gear_mode;
wire [2:0] rx_w = gear_width(i_gear_mode);
wire [2:0] tx_w = gear_width(out_mode);
reg [2:0] rx_cnt_r;
reg align_pend_r;
reg word_done_r;
reg word_ready_r;
wire rx_last = (rx_cnt_r == rx_w - 3'h1);

always @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        rx_cnt_r <= 3'h0;
        align_pend_r <= 1'b0;
        word_done_r <= 1'b0;
        word_ready_r <= 1'b0;
        o_rx_word_valid <= 1'b0;
    end
    else
    begin
        word_done_r <= 1'b0;
        if (rd_vld_r && align_pend_r)
            align_pend_r <= i_word_align_request;
        else
        begin
            if (i_word_align_request)
                align_pend_r <= 1'b1;
            if (rd_vld_r)
            begin
                rx_cnt_r <= rx_last ? 3'h0 : rx_cnt_r + 3'h1;
                word_done_r <= rx_last;
            end
        end
        o_rx_word_valid <= 1'b0;
        if (slw_rise)
        begin
            o_rx_word_valid <= word_ready_r | word_done_r;
            word_ready_r <= 1'b0;
        end
        else if (word_done_r)
            word_ready_r <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Write clock generator
// ----------------------------------------------------------------
reg [1:0] ph_r;
reg tx_active_r;
wire dq_shift = (ph_r == `DGF_PH_SHIFT);
wire wclk_nxt = (ph_r == 2'h0) || (ph_r == 2'h1);
reg [1:0] wclk_dly_r;

always @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        ph_r <= `DGF_PH_RESET;
        o_strobe_write_clock <= 1'b0;
        o_data_write_clock_270 <= 1'b0;
        wclk_dly_r <= 2'h0;
        o_strobe_p <= 1'b0;
        o_strobe_n <= 1'b1;
        o_tristate_out <= 1'b1;
        tx_active_r <= 1'b0;
    end
    else
    begin
        ph_r <= ph_r + 2'h1;
        // High in quarters 1 and 2, whole pulses from reset on
        o_strobe_write_clock <= wclk_nxt;
        // Strobe write clock delayed three cycles: 270 degrees
        wclk_dly_r <= {wclk_dly_r[0], o_strobe_write_clock};
        o_data_write_clock_270 <= wclk_dly_r[1];
        if (slw_rise)
            tx_active_r <= ~i_tristate_in[0];
        // Strobe pair follows the strobe write clock while driving
        o_strobe_p <= tx_active_r & wclk_nxt;
        o_strobe_n <= ~(tx_active_r & wclk_nxt);
        if (i_tristate_two_to_one_gear && dq_shift)
        begin
            o_tristate_out <= o_tristate_out ? i_tristate_in[0]
                : i_tristate_in[1];
        end
        else if (!i_tristate_two_to_one_gear && slw_rise)
            o_tristate_out <= i_tristate_in[0];
    end
end

// ----------------------------------------------------------------
// Per pin gearing
// ----------------------------------------------------------------
genvar p;
generate
    for (p = 0; p < NUM_DATA; p = p + 1)
    begin : g_pin
        reg [`DGF_WORD_MAX-1:0] rx_sh_r;
        reg [`DGF_WORD_MAX-1:0] rx_hold_r;
        reg [`DGF_WORD_MAX-1:0] rx_word_r;
        reg [`DGF_WORD_MAX-1:0] tx_sh_r;
        reg [2:0] tx_cnt_r;
        reg dq_r;
        wire [`DGF_WORD_MAX-1:0] rx_next =
            {rx_sh_r[`DGF_WORD_MAX-2:0], fifo_rdata[p]};
        always @(posedge i_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                rx_sh_r <= {`DGF_WORD_MAX{1'b0}};
                rx_hold_r <= {`DGF_WORD_MAX{1'b0}};
                rx_word_r <= {`DGF_WORD_MAX{1'b0}};
                tx_sh_r <= {`DGF_WORD_MAX{1'b0}};
                tx_cnt_r <= 3'h0;
                dq_r <= 1'b0;
            end
            else
            begin
                if (rd_vld_r && !align_pend_r)
                begin
                    rx_sh_r <= rx_next;
                    if (rx_last)
                        rx_hold_r <= rx_next &
                            ~({`DGF_WORD_MAX{1'b1}} << rx_w);
                end
                if (slw_rise)
                begin
                    rx_word_r <= rx_hold_r;
                    tx_sh_r <= i_tx_word[p*`DGF_WORD_MAX +:
                        `DGF_WORD_MAX];
                    tx_cnt_r <= 3'h0;
                end
                else if (dq_shift && tx_cnt_r != tx_w)
                begin
                    dq_r <= tx_sh_r[0];
                    tx_sh_r <= tx_sh_r >> 1;
                    tx_cnt_r <= tx_cnt_r + 3'h1;
                end
            end
        end
        assign o_rx_word[p*`DGF_WORD_MAX +: `DGF_WORD_MAX] = rx_word_r;
        assign o_dq_out[p] = dq_r;
    end
endgenerate

endmodule

// File: sim/dgf_mem_model.sv
// Memory device side: strobe and data bursts
`timescale 1ns/1ps
module dgf_mem_model #(
    parameter NUM_DATA = 14
) (
    // Burst request
    input logic i_go,
    input logic [NUM_DATA-1:0] i_beat,
    input logic [5:0] i_len,
    // Pins toward the group
    output logic o_strobe,
    output logic [NUM_DATA-1:0] o_dq,
    output logic o_busy
);
    initial
    begin
        o_strobe = 1'h0;
        o_dq = '0;
        o_busy = 1'h0;
    end
    // Strobe stands still outside bursts
    always @(posedge i_go)
    begin
        o_busy = 1'h1;
        repeat (i_len)
        begin
            o_dq = i_beat;
            #20.3 o_strobe = ~o_strobe;
            #19.7;
        end
        o_dq = ~i_beat;
        o_busy = 1'h0;
    end
endmodule

// File: sim/dgf_strobe_group_sva.sv
// Port checks for one strobe group
`timescale 1ns/1ps
module dgf_sg_sva #(
    parameter AW = 3
) (
    // Clock and reset
    input logic i_clk,
    input logic i_rst_n,
    // Link clocks
    input logic i_strobe_delayed,
    input logic i_edge_clock,
    // Watched outputs
    input logic o_rx_word_valid,
    input logic o_strobe_p,
    input logic o_strobe_n,
    input logic o_strobe_write_clock,
    input logic o_data_write_clock_270,
    input logic [AW:0] o_wr_ptr,
    input logic [AW:0] o_rd_ptr
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    wclk_shape_a: assert property (
        $rose(o_strobe_write_clock) |=> o_strobe_write_clock
        ##1 !o_strobe_write_clock [*2] ##1 o_strobe_write_clock)
        else $error("strobe write clock shape wrong");
    data_lag_a: assert property (
        o_data_write_clock_270 == $past(o_strobe_write_clock, 3))
        else $error("data write clock not three cycles late");
    strobe_pair_a: assert property (
        o_strobe_p |-> !o_strobe_n)
        else $error("strobe pair not complementary");
    strobe_follow_a: assert property (
        o_strobe_p |-> o_strobe_write_clock)
        else $error("strobe runs outside write clock");
    wptr_step_a: assert property (
        o_wr_ptr != $past(o_wr_ptr) |-> o_wr_ptr == $past(o_wr_ptr) + 1'h1)
        else $error("write pointer jumped");
    ptr_bound_a: assert property (
        (AW+1)'(o_wr_ptr - o_rd_ptr) <= (1 << AW))
        else $error("read pointer passed write pointer");
    wr_idle_a: assert property (
        $stable(i_strobe_delayed) [*8] |=> $stable(o_wr_ptr))
        else $error("write without strobe edge");
    rd_idle_a: assert property (
        $stable(i_edge_clock) [*8] |=> $stable(o_rd_ptr))
        else $error("read without edge clock edge");
    valid_pulse_a: assert property (
        o_rx_word_valid |=> !o_rx_word_valid)
        else $error("word valid longer than one cycle");
endmodule
bind dgf_strobe_group dgf_sg_sva #(.AW(AW)) u_dgf_sg_sva (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_strobe_delayed(i_strobe_delayed),
    .i_edge_clock(i_edge_clock), .o_rx_word_valid(o_rx_word_valid),
    .o_strobe_p(o_strobe_p), .o_strobe_n(o_strobe_n),
    .o_strobe_write_clock(o_strobe_write_clock),
    .o_data_write_clock_270(o_data_write_clock_270),
    .o_wr_ptr(o_wr_ptr), .o_rd_ptr(o_rd_ptr));

// File: sim/tb.sv
// Random burst bench for one strobe group
`timescale 1ns/1ps
`include "dgf_map.vh"
module tb;
    logic i_clk = 1'h0, i_rst_n = 1'h0, i_edge_clock = 1'h0;
    logic i_slow_clock = 1'h0, go = 1'h0, i_word_align_request = 1'h0;
    logic i_tristate_two_to_one_gear = 1'h0, b, busy, o_rx_word_valid;
    logic i_strobe_delayed, o_tristate_out;
    logic [1:0] i_gear_mode = 2'h0, i_tristate_in = 2'h0;
    logic [13:0] v = 14'h0000, u, i_dq_in, o_dq_out;
    logic [3:0] o_wr_ptr, o_rd_ptr;
    logic [97:0] i_tx_word = '0, o_rx_word;
    int wtab[4] = '{2, 4, 7, 2};
    logic [1:0] mtab[4] = '{`DGF_MODE_X1, `DGF_MODE_X2, `DGF_MODE_7TO1,
        2'h3};
    int w = 2, nval, k, failures, compares, cyc;
    real hp = 40.0;
    // ----------------------------------------------------------------
    // Clocks
    // ----------------------------------------------------------------
    always #2 i_clk = ~i_clk;
    initial
    begin
        #1.3;
        forever #40 i_edge_clock = ~i_edge_clock;
    end
    always #(hp) i_slow_clock = ~i_slow_clock;
    // ----------------------------------------------------------------
    // Instances
    // ----------------------------------------------------------------
    dgf_strobe_group u_dgf_strobe_group (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_strobe_delayed(i_strobe_delayed),
        .i_edge_clock(i_edge_clock), .i_slow_clock(i_slow_clock),
        .i_dq_in(i_dq_in), .i_gear_mode(i_gear_mode),
        .i_word_align_request(i_word_align_request),
        .i_tristate_two_to_one_gear(i_tristate_two_to_one_gear),
        .i_tristate_in(i_tristate_in), .i_tx_word(i_tx_word),
        .o_rx_word(o_rx_word), .o_rx_word_valid(o_rx_word_valid),
        .o_dq_out(o_dq_out), .o_tristate_out(o_tristate_out),
        .o_strobe_p(), .o_strobe_n(), .o_strobe_write_clock(),
        .o_data_write_clock_270(), .o_wr_ptr(o_wr_ptr), .o_rd_ptr(o_rd_ptr));
    dgf_mem_model u_dgf_mem_model (.i_go(go), .i_beat(v), .i_len(6'h1c),
        .o_strobe(i_strobe_delayed), .o_dq(i_dq_in), .o_busy(busy));
    // ----------------------------------------------------------------
    // Expectations and reporting
    // ----------------------------------------------------------------
    function automatic logic [97:0] rx_exp(input logic [13:0] d, input int n);
        rx_exp = '0;
        for (int p = 0; p < 14; p++)
            rx_exp[p*7 +: 7] = d[p] ? 7'h7f >> (7 - n) : 7'h00;
    endfunction
    function automatic logic [97:0] tx_rep(input logic [13:0] d);
        for (int p = 0; p < 14; p++)
            tx_rep[p*7 +: 7] = {7{d[p]}};
    endfunction
    task check(input string name, input logic [97:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task close_out;
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(negedge i_clk)
        if (i_rst_n && o_rx_word_valid === 1'h1)
        begin
            nval++;
            check("rx_word", o_rx_word, rx_exp(v, w));
        end
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            failures++;
            close_out;
        end
    end
    // ----------------------------------------------------------------
    // Main sequence: one burst per mode code, 2'h3 included
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h0000_eed7));
        for (int i = 0; i < 4; i++)
        begin
            @(posedge i_clk);
            i_rst_n <= 1'h0;
            i_gear_mode <= mtab[i];
            v = 14'($urandom);
            u = 14'($urandom);
            b = 1'($urandom);
            i_tx_word <= tx_rep(u);
            i_tristate_in <= {b, b};
            i_tristate_two_to_one_gear <= i[0];
            repeat (12) @(posedge i_clk);
            w = wtab[i];
            hp = 20.0 * w;
            nval = 0;
            i_rst_n <= 1'h1;
            @(negedge i_clk);
            check("wr_ptr_rst", o_wr_ptr, 4'h0);
            @(posedge i_clk);
            go <= 1'h1;
            for (k = 0; k < 400 && (k < 2 || busy); k++)
                @(posedge i_clk) i_word_align_request <= (k == 50);
            go <= 1'h0;
            for (k = 0; k < 100 && o_rd_ptr !== o_wr_ptr; k++)
                @(posedge i_clk);
            for (k = 0; k < 200 && nval < 28 / w; k++)
                @(posedge i_clk);
            @(negedge i_clk);
            check("wr_ptr", o_wr_ptr, 4'hc);
            check("rd_ptr", o_rd_ptr, 4'hc);
            check("words", nval > 0, 1'h1);
            check("dq_out", o_dq_out, u);
            check("tristate", o_tristate_out, b);
        end
        close_out;
    end
endmodule
